// ---- verilog/nvm_top.sv ----
// nonvolatile data window: bus registers, data move decode, page programming
// Behaviour
// - array appears at data addresses 0000h-07ffh only while the window is selected
// - data moves reach the array only when the select bit is set
// - selected read returns the stored byte at the pointer address
// - writing is two steps: load column latch, then program one row
// - one to 128 latched bytes form one page program
// - a flag per latched byte; only flagged bytes are programmed
// - loading sets a byte flag; finishing the row clears all flags
// - latch loads are single-byte data-move writes while selected
// - 11-bit address: upper 4 bits page, lower 7 bits byte
// - writing key 5 then key a to control launches programming
// - any access between the two key writes cancels the launch
// - busy flag set while programming, array reads blocked, cleared at end
// - page of the first load is kept; later loads from other pages land at their byte index in that page
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
module nvm_top #(
    parameter int PROG_CYCLES = nvm_pkg::PROG_CYCLES_DEFAULT
) (
    input wire clock_i,
    input wire rst_i,
    input wire [nvm_pkg::AVS_ADDR_W-1:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire [nvm_pkg::XD_ADDR_W-1:0] xd_addr_i,
    input wire xd_read_i,
    input wire xd_write_i,
    input wire [7:0] xd_wdata_i,
    output logic [7:0] xd_rdata_o,
    output logic xd_ready_o,
    output logic [nvm_pkg::XD_ADDR_W-1:0] extended_data_ram_addr_o,
    output logic extended_data_ram_read_o,
    output logic extended_data_ram_write_o,
    output logic [7:0] extended_data_ram_wdata_o,
    input wire [7:0] extended_data_ram_rdata_i,
    output logic busy_o
);
    localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

    nvm_lat_if lat ();
    nvm_mem_if mem ();

    nvm_pkg::nvm_state_t state;
    nvm_pkg::nvm_state_t next_state;
    logic sel;
    logic armed;
    logic busy;
    logic [nvm_pkg::IDX_W-1:0] idx;
    logic [31:0] wait_cnt;
    logic [nvm_pkg::PAGE_W-1:0] prog_page;

    // bus side
    logic avs_req;
    logic avs_ph;
    logic avs_take;
    logic avs_start;
    logic ctrl_wr;
    logic [3:0] key;
    logic launch;

    // data move side
    logic xd_req;
    logic [1:0] xph;
    logic xd_start;
    logic xd_hit;
    logic hit_nvm;

    // ****************************************
    // submodules
    // ****************************************
    nvm_latch u_latch (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .lat(lat.latch)
    );

    nvm_array u_array (
        .clock_i(clock_i),
        .mem(mem.mem)
    );

    // ****************************************
    // register bus slave
    // ****************************************
    // every access waits one cycle; it completes when avs_ph is high
    assign avs_req = avs_read_i | avs_write_i;
    assign avs_start = avs_req & ~avs_ph;
    assign avs_take = avs_req & avs_ph;
    assign avs_waitrequest_o = avs_req & ~avs_ph;

    // wait phase of the bus handshake
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            avs_ph <= 1'b0;
        end else begin
            avs_ph <= avs_start;
        end
    end

    // read data captured one edge ahead so it stands when waitrequest drops
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= '0;
        end else if (avs_start && avs_read_i) begin
            avs_readdata_o <= nvm_pkg::UNMAPPED_DATA;
            case (avs_address_i)
                nvm_pkg::REG_CTRL: begin
                    avs_readdata_o[nvm_pkg::CTRL_SEL_BIT] <= sel;
                    avs_readdata_o[nvm_pkg::CTRL_BUSY_BIT] <= busy;
                end
                nvm_pkg::REG_STAT: begin
                    avs_readdata_o[nvm_pkg::STAT_BUSY_BIT] <= busy;
                    avs_readdata_o[nvm_pkg::STAT_ANY_BIT] <= lat.any;
                    avs_readdata_o[nvm_pkg::STAT_ARMED_BIT] <= armed;
                    avs_readdata_o[nvm_pkg::STAT_PAGE_LSB +: nvm_pkg::PAGE_W] <= lat.page;
                end
                default: begin
                    avs_readdata_o <= nvm_pkg::UNMAPPED_DATA;
                end
            endcase
        end
    end

    // control write decode; the key sits in the upper nibble of the low byte
    assign ctrl_wr = avs_take & avs_write_i & avs_byteenable_i[0] & (avs_address_i == nvm_pkg::REG_CTRL);
    assign key = avs_writedata_i[nvm_pkg::CTRL_KEY_LSB +: 4];

    // ****************************************
    // control register and launch key
    // ****************************************
    // window select bit, writable at any time
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sel <= nvm_pkg::CTRL_SEL_RESET;
        end else if (ctrl_wr) begin
            sel <= avs_writedata_i[nvm_pkg::CTRL_SEL_BIT];
        end
    end

    // second key must be the very next access after the first
    assign launch = ctrl_wr & armed & (key == nvm_pkg::KEY_GO) & ~busy;

    // key arming: any other bus or data move access disarms
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            armed <= 1'b0;
        end else if (ctrl_wr && (key == nvm_pkg::KEY_ARM) && !busy) begin
            armed <= 1'b1;
        end else if (avs_take || xd_start) begin
            armed <= 1'b0;
        end
    end

    // ****************************************
    // data move decode
    // ****************************************
    // four phases: start, array read, capture, ready
    assign xd_req = xd_read_i | xd_write_i;
    assign xd_start = xd_req & (xph == 2'h0);
    assign xd_hit = sel & (xd_addr_i[nvm_pkg::XD_ADDR_W-1:nvm_pkg::NVM_ADDR_W] == nvm_pkg::XD_HI_NVM);
    assign xd_ready_o = xd_req & (xph == nvm_pkg::XPH_LAST);

    // phase counter of a data move
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            xph <= 2'h0;
        end else if (xd_req) begin
            xph <= xph + 2'h1;
        end else begin
            xph <= 2'h0;
        end
    end

    // route chosen at the start holds for the whole move
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            hit_nvm <= 1'b0;
        end else if (xd_start) begin
            hit_nvm <= xd_hit;
        end
    end

    // deselected window passes the move to extended data ram
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            extended_data_ram_addr_o <= '0;
            extended_data_ram_wdata_o <= '0;
            extended_data_ram_read_o <= 1'b0;
            extended_data_ram_write_o <= 1'b0;
        end else begin
            extended_data_ram_read_o <= xd_start & xd_read_i & ~xd_hit;
            extended_data_ram_write_o <= xd_start & xd_write_i & ~xd_hit;
            if (xd_start) begin
                extended_data_ram_addr_o <= xd_addr_i;
                extended_data_ram_wdata_o <= xd_wdata_i;
            end
        end
    end

    // read data: array byte, blocked value while busy, or ram byte
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            xd_rdata_o <= '0;
        end else if (xd_read_i && (xph == 2'h2)) begin
            if (!hit_nvm) begin
                xd_rdata_o <= extended_data_ram_rdata_i;
            end else if (busy) begin
                xd_rdata_o <= nvm_pkg::BLOCKED_READ;
            end else begin
                xd_rdata_o <= mem.rd_data;
            end
        end
    end

    // array read address straight from the held pointer
    assign mem.rd_addr = xd_addr_i[nvm_pkg::NVM_ADDR_W-1:0];

    // latch load: one byte per selected write, dropped while busy
    assign lat.load = xd_start & xd_write_i & xd_hit & ~busy;
    assign lat.load_addr = xd_addr_i[nvm_pkg::NVM_ADDR_W-1:0];
    assign lat.load_data = xd_wdata_i;

    // ****************************************
    // page program sequencer
    // ****************************************
    assign busy = (state != nvm_pkg::NVM_IDLE);
    assign busy_o = busy;

    // next state
    always_comb begin
        next_state = state;
        case (state)
            nvm_pkg::NVM_IDLE: begin
                if (launch) begin
                    next_state = nvm_pkg::NVM_WALK;
                end
            end
            nvm_pkg::NVM_WALK: begin
                if (idx == nvm_pkg::IDX_W'(nvm_pkg::PAGE_BYTES - 1)) begin
                    next_state = nvm_pkg::NVM_SETTLE;
                end
            end
            nvm_pkg::NVM_SETTLE: begin
                if (wait_cnt == PROG_LAST) begin
                    next_state = nvm_pkg::NVM_IDLE;
                end
            end
            default: begin
                next_state = nvm_pkg::NVM_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= nvm_pkg::NVM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // byte walk over the page, page frozen at launch
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            idx <= '0;
            prog_page <= '0;
        end else if (launch) begin
            idx <= '0;
            prog_page <= lat.page;
        end else if (state == nvm_pkg::NVM_WALK) begin
            idx <= idx + 1'b1;
        end
    end

    // cell programming time after the walk
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt <= '0;
        end else if (state == nvm_pkg::NVM_SETTLE) begin
            wait_cnt <= wait_cnt + 32'h1;
        end else begin
            wait_cnt <= '0;
        end
    end

    // only flagged bytes reach the row, the rest keep their value
    assign lat.rd_idx = idx;
    assign mem.we = (state == nvm_pkg::NVM_WALK) & lat.rd_flag;
    assign mem.wr_addr = {prog_page, idx};
    assign mem.wr_data = lat.rd_data;

    // latch flags emptied when the row is done
    assign lat.clear = (state == nvm_pkg::NVM_SETTLE) & (wait_cnt == PROG_LAST);
endmodule : nvm_top

// ---- verilog/nvm_pkg.sv ----
// constants shared by the nonvolatile data window block
package nvm_pkg;
    // ****************************************
    // array geometry
    // ****************************************
    localparam int NVM_ADDR_W = 11;
    localparam int PAGE_W = 4;
    localparam int IDX_W = 7;
    localparam int PAGE_BYTES = 128;
    localparam int XD_ADDR_W = 16;
    localparam logic [4:0] XD_HI_NVM = 5'h00; // addresses 0000h..07ffh

    // ****************************************
    // register map, byte addresses on the bus
    // ****************************************
    localparam int AVS_ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_BUSY_BIT = 1;
    localparam int CTRL_KEY_LSB = 4;
    localparam logic [3:0] KEY_ARM = 4'h5;
    localparam logic [3:0] KEY_GO = 4'ha;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ANY_BIT = 1;
    localparam int STAT_ARMED_BIT = 2;
    localparam int STAT_PAGE_LSB = 4;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // ****************************************
    // data values and timing
    // ****************************************
    localparam logic [7:0] BLOCKED_READ = 8'hff;
    localparam logic CTRL_SEL_RESET = 1'b0;
    localparam int PROG_CYCLES_DEFAULT = 1000;
    localparam logic [1:0] XPH_LAST = 2'h3;

    // program sequencer states
    typedef enum logic [2:0] {
        NVM_IDLE = 3'b001,
        NVM_WALK = 3'b010,
        NVM_SETTLE = 3'b100
    } nvm_state_t;
endpackage : nvm_pkg

// ---- verilog/nvm_if.sv ----
// carriers between the window controller, the column latch and the array
`timescale 1ns/10ps
interface nvm_lat_if;
    logic load;
    logic [nvm_pkg::NVM_ADDR_W-1:0] load_addr;
    logic [7:0] load_data;
    logic clear;
    logic [nvm_pkg::IDX_W-1:0] rd_idx;
    logic [7:0] rd_data;
    logic rd_flag;
    logic [nvm_pkg::PAGE_W-1:0] page;
    logic any;
    modport ctrl (output load, load_addr, load_data, clear, rd_idx, input rd_data, rd_flag, page, any);
    modport latch (input load, load_addr, load_data, clear, rd_idx, output rd_data, rd_flag, page, any);
endinterface : nvm_lat_if

interface nvm_mem_if;
    logic [nvm_pkg::NVM_ADDR_W-1:0] rd_addr;
    logic [7:0] rd_data;
    logic we;
    logic [nvm_pkg::NVM_ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    modport ctrl (output rd_addr, we, wr_addr, wr_data, input rd_data);
    modport mem (input rd_addr, we, wr_addr, wr_data, output rd_data);
endinterface : nvm_mem_if

// ---- verilog/nvm_latch.sv ----
// column latch: one page of bytes, a written flag per byte, the captured page
`timescale 1ns/10ps
module nvm_latch (
    input wire clock_i,
    input wire rst_i,
    nvm_lat_if.latch lat
);
    logic [7:0] data [nvm_pkg::PAGE_BYTES];
    logic [nvm_pkg::PAGE_BYTES-1:0] flag;
    logic [nvm_pkg::PAGE_W-1:0] page;
    logic any;

    // ****************************************
    // storage
    // ****************************************
    // byte store, no reset needed: flags tell what is valid
    always_ff @(posedge clock_i) begin
        if (lat.load) begin
            data[lat.load_addr[nvm_pkg::IDX_W-1:0]] <= lat.load_data;
        end
    end

    // one flag per byte; a load in the clearing cycle keeps its flag
    genvar i;
    generate
        for (i = 0; i < nvm_pkg::PAGE_BYTES; i = i + 1) begin : g_flag
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    flag[i] <= 1'b0;
                end else if (lat.load && (lat.load_addr[nvm_pkg::IDX_W-1:0] == nvm_pkg::IDX_W'(i))) begin
                    flag[i] <= 1'b1;
                end else if (lat.clear) begin
                    flag[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // page of the first load is kept until the latch is emptied
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            page <= '0;
            any <= 1'b0;
        end else if (lat.load) begin
            if (!any || lat.clear) begin
                page <= lat.load_addr[nvm_pkg::NVM_ADDR_W-1:nvm_pkg::IDX_W];
            end
            any <= 1'b1;
        end else if (lat.clear) begin
            any <= 1'b0;
        end
    end

    // ****************************************
    // read side for the program walk
    // ****************************************
    assign lat.rd_data = data[lat.rd_idx];
    assign lat.rd_flag = flag[lat.rd_idx];
    assign lat.page = page;
    assign lat.any = any;
endmodule : nvm_latch

// ---- verilog/nvm_array.sv ----
// nonvolatile byte array: registered read port, byte program port
`timescale 1ns/10ps
module nvm_array (
    input wire clock_i,
    nvm_mem_if.mem mem
);
    logic [7:0] cells [2**nvm_pkg::NVM_ADDR_W];
    logic [7:0] rd_data;

    // ****************************************
    // cell access
    // ****************************************
    // program one byte, read one byte a cycle later
    always_ff @(posedge clock_i) begin
        if (mem.we) begin
            cells[mem.wr_addr] <= mem.wr_data;
        end
        rd_data <= cells[mem.rd_addr];
    end

    assign mem.rd_data = rd_data;
endmodule : nvm_array

// ---- bench/nvm_extended_data_ram_model.sv ----
// extended data ram seen on the far side of the window block
`timescale 1ns/10ps
module nvm_extended_data_ram_model (
    input wire clock_i,
    input wire [15:0] extended_data_ram_addr_i,
    input wire extended_data_ram_read_i,
    input wire extended_data_ram_write_i,
    input wire [7:0] extended_data_ram_wdata_i,
    output logic [7:0] extended_data_ram_rdata_o
);
    logic [7:0] mem [0:65535];
    // store writes; read data valid only in the cycle after the read pulse
    always @(posedge clock_i) begin
        if (extended_data_ram_write_i) begin
            mem[extended_data_ram_addr_i] <= extended_data_ram_wdata_i;
        end
        if (extended_data_ram_read_i) begin
            extended_data_ram_rdata_o <= mem[extended_data_ram_addr_i];
        end else begin
            extended_data_ram_rdata_o <= ~extended_data_ram_rdata_o; // stale data never looks valid
        end
    end
endmodule : nvm_extended_data_ram_model

// ---- bench/nvm_top_checker.sv ----
// port assertions for the nonvolatile data window
`timescale 1ns/10ps
module nvm_top_checker #(
    parameter int PROG_CYCLES = nvm_pkg::PROG_CYCLES_DEFAULT
) (
    input wire clock_i,
    input wire rst_i,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_writedata_i,
    input wire avs_waitrequest_o,
    input wire [15:0] xd_addr_i,
    input wire xd_read_i,
    input wire xd_write_i,
    input wire [7:0] xd_wdata_i,
    input wire [7:0] xd_rdata_o,
    input wire xd_ready_o,
    input wire [15:0] extended_data_ram_addr_o,
    input wire extended_data_ram_read_o,
    input wire extended_data_ram_write_o,
    input wire [7:0] extended_data_ram_wdata_o,
    input wire busy_o
);
    // ****************************************
    // helper state
    // ****************************************
    logic sel;
    int busy_cnt;
    logic in_win;
    assign in_win = sel && (xd_addr_i[15:11] == nvm_pkg::XD_HI_NVM);
    // follow the select bit through accepted control writes
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sel <= nvm_pkg::CTRL_SEL_RESET;
        end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == nvm_pkg::REG_CTRL && avs_byteenable_i[0]) begin
            sel <= avs_writedata_i[nvm_pkg::CTRL_SEL_BIT];
        end
    end
    // length of the current busy stretch
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_o ? busy_cnt + 1 : 0;
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_wait_first;
        ($rose(avs_read_i) || $rose(avs_write_i)) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("waitrequest not one cycle");
    property p_wait_idle;
        !avs_read_i && !avs_write_i |-> !avs_waitrequest_o;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest while idle");
    property p_ready_fourth;
        ($rose(xd_read_i) || $rose(xd_write_i)) |-> !xd_ready_o [*3] ##1 xd_ready_o;
    endproperty
    a_ready_fourth: assert property (p_ready_fourth) else $error("move ready not in fourth cycle");
    property p_busy_len;
        $fell(busy_o) |-> busy_cnt == 128 + PROG_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_launch;
        $rose(busy_o) |-> $past(avs_write_i && !avs_waitrequest_o && avs_address_i == nvm_pkg::REG_CTRL
            && avs_writedata_i[nvm_pkg::CTRL_KEY_LSB +: 4] == nvm_pkg::KEY_GO);
    endproperty
    a_launch: assert property (p_launch) else $error("busy without launch key");
    property p_extended_data_ram_write;
        $rose(xd_write_i) && !in_win |=> extended_data_ram_write_o && extended_data_ram_wdata_o == xd_wdata_i && extended_data_ram_addr_o == xd_addr_i;
    endproperty
    a_extended_data_ram_write: assert property (p_extended_data_ram_write) else $error("write not sent to ram");
    property p_win_write;
        $rose(xd_write_i) && in_win |=> !extended_data_ram_write_o [*3];
    endproperty
    a_win_write: assert property (p_win_write) else $error("window write leaked to ram");
    property p_extended_data_ram_read;
        $rose(xd_read_i) && !in_win |-> ##[1:2] (extended_data_ram_read_o && extended_data_ram_addr_o == xd_addr_i);
    endproperty
    a_extended_data_ram_read: assert property (p_extended_data_ram_read) else $error("read not sent to ram");
    property p_blocked;
        ($rose(xd_read_i) && in_win && busy_o) ##2 busy_o |-> ##1 (xd_ready_o && xd_rdata_o == nvm_pkg::BLOCKED_READ);
    endproperty
    a_blocked: assert property (p_blocked) else $error("array read not blocked");
endmodule : nvm_top_checker
bind nvm_top nvm_top_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.clock_i(clock_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
    .xd_addr_i(xd_addr_i), .xd_read_i(xd_read_i), .xd_write_i(xd_write_i), .xd_wdata_i(xd_wdata_i),
    .xd_rdata_o(xd_rdata_o), .xd_ready_o(xd_ready_o), .extended_data_ram_addr_o(extended_data_ram_addr_o), .extended_data_ram_read_o(extended_data_ram_read_o),
    .extended_data_ram_write_o(extended_data_ram_write_o), .extended_data_ram_wdata_o(extended_data_ram_wdata_o), .busy_o(busy_o));

// ---- bench/nvm_top_test.sv ----
// self-checking bench for the nonvolatile data window
`timescale 1ns/10ps
module nvm_top_test;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [15:0] xd_addr_i = 16'h0;
    logic xd_read_i = 1'b0;
    logic xd_write_i = 1'b0;
    logic [7:0] xd_wdata_i = 8'h0;
    logic [7:0] xd_rdata_o, extended_data_ram_wdata_o, extended_data_ram_rdata_i, x;
    logic xd_ready_o, extended_data_ram_read_o, extended_data_ram_write_o, busy_o;
    logic [15:0] extended_data_ram_addr_o;
    logic [31:0] rd;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    // ****************************************
    // clock, design and ram model
    // ****************************************
    always #4 clock_i = ~clock_i;
    nvm_top #(.PROG_CYCLES(10)) dut_u (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(4'hf),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .xd_addr_i(xd_addr_i), .xd_read_i(xd_read_i), .xd_write_i(xd_write_i), .xd_wdata_i(xd_wdata_i),
        .xd_rdata_o(xd_rdata_o), .xd_ready_o(xd_ready_o), .extended_data_ram_addr_o(extended_data_ram_addr_o), .extended_data_ram_read_o(extended_data_ram_read_o),
        .extended_data_ram_write_o(extended_data_ram_write_o), .extended_data_ram_wdata_o(extended_data_ram_wdata_o), .extended_data_ram_rdata_i(extended_data_ram_rdata_i), .busy_o(busy_o));
    nvm_extended_data_ram_model ram_u (.clock_i(clock_i), .extended_data_ram_addr_i(extended_data_ram_addr_o), .extended_data_ram_read_i(extended_data_ram_read_o),
        .extended_data_ram_write_i(extended_data_ram_write_o), .extended_data_ram_wdata_i(extended_data_ram_wdata_o), .extended_data_ram_rdata_o(extended_data_ram_rdata_i));
    // ****************************************
    // tasks
    // ****************************************
    task automatic final_report();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // bus cycle held until waitrequest is seen low at a rising edge
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
        logic w;
        w = 1'b1;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        while (w !== 1'b0) begin
            @(posedge clock_i);
            w = avs_waitrequest_o;
            rd = avs_readdata_o;
        end
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clock_i);
    endtask : avs
    // data move held until ready; callers may mix pages in one session
    task automatic xd(input logic wr, input logic [15:0] a, input logic [7:0] d);
        logic r;
        r = 1'b0;
        xd_addr_i <= a;
        xd_wdata_i <= d;
        xd_write_i <= wr;
        xd_read_i <= !wr;
        while (r !== 1'b1) begin
            @(posedge clock_i);
            r = xd_ready_o;
            x = xd_rdata_o;
        end
        xd_write_i <= 1'b0;
        xd_read_i <= 1'b0;
        @(posedge clock_i);
    endtask : xd
    // launch a row program, poke at it while busy, wait for the end
    task automatic launch();
        int n;
        avs(1'b1, nvm_pkg::REG_CTRL, 32'h0000_0051);
        avs(1'b1, nvm_pkg::REG_CTRL, 32'h0000_00a1);
        check(busy_o, 1'b1);
        xd(1'b1, 16'h0185, 8'h99);
        xd(1'b0, 16'h0180, 8'h00);
        check(x, nvm_pkg::BLOCKED_READ);
        avs(1'b0, nvm_pkg::REG_CTRL, 32'h0);
        check(rd[nvm_pkg::CTRL_BUSY_BIT], 1'b1);
        n = 0;
        while (busy_o !== 1'b0 && n < 400) begin
            @(negedge clock_i);
            n++;
        end
        @(posedge clock_i);
        check(busy_o, 1'b0);
        avs(1'b0, nvm_pkg::REG_STAT, 32'h0);
        check(rd[1:0], 2'h0);
    endtask : launch
    // ****************************************
    // timeout and main sequence
    // ****************************************
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        avs(1'b0, nvm_pkg::REG_CTRL, 32'h0);
        check(rd, 32'h0);
        xd(1'b1, 16'h0185, 8'h3c);
        xd(1'b0, 16'h0185, 8'h00);
        check(x, 8'h3c);
        avs(1'b1, nvm_pkg::REG_CTRL, 32'h0000_0001);
        avs(1'b1, 4'h8, 32'hffff_ffff);
        avs(1'b0, 4'h8, 32'h0);
        check(rd, nvm_pkg::UNMAPPED_DATA);
        avs(1'b0, nvm_pkg::REG_CTRL, 32'h0);
        check(rd[1:0], 2'h1);
        xd(1'b1, 16'h0900, 8'h77);
        xd(1'b0, 16'h0900, 8'h00);
        check(x, 8'h77);
        // first session: both index ends, a middle byte, a stray page
        xd(1'b1, 16'h0180, 8'h11);
        xd(1'b1, 16'h01ff, 8'h22);
        xd(1'b1, 16'h0185, 8'h33);
        xd(1'b1, 16'h0282, 8'h44);
        avs(1'b0, nvm_pkg::REG_STAT, 32'h0);
        check(rd[7:0], 8'h32);
        // key pair split by a status read and a data move must not start programming
        avs(1'b1, nvm_pkg::REG_CTRL, 32'h0000_0051);
        avs(1'b0, nvm_pkg::REG_STAT, 32'h0);
        check(rd[nvm_pkg::STAT_ARMED_BIT], 1'b1);
        xd(1'b0, 16'h0900, 8'h00);
        avs(1'b1, nvm_pkg::REG_CTRL, 32'h0000_00a1);
        check(busy_o, 1'b0);
        launch();
        xd(1'b0, 16'h0180, 8'h00);
        check(x, 8'h11);
        xd(1'b0, 16'h01ff, 8'h00);
        check(x, 8'h22);
        xd(1'b0, 16'h0185, 8'h00);
        check(x, 8'h33);
        xd(1'b0, 16'h0182, 8'h00);
        check(x, 8'h44);
        // second session: one byte only, the rest of the row must hold
        xd(1'b1, 16'h0180, 8'h55);
        launch();
        xd(1'b0, 16'h0180, 8'h00);
        check(x, 8'h55);
        xd(1'b0, 16'h0185, 8'h00);
        check(x, 8'h33);
        xd(1'b0, 16'h01ff, 8'h00);
        check(x, 8'h22);
        avs(1'b1, nvm_pkg::REG_CTRL, 32'h0);
        xd(1'b0, 16'h0185, 8'h00);
        check(x, 8'h3c);
        final_report();
    end
endmodule : nvm_top_test
